// ==== rtl/dci_pkg.sv ====
`default_nettype none
package dci_pkg;
	// register offsets
	localparam logic [7:0] ADDR_REVISION = 8'h0b;
	localparam logic [7:0] ADDR_CONTROL  = 8'h0c;
	localparam logic [7:0] ADDR_LIVE     = 8'h0d;
	localparam logic [7:0] ADDR_MASK     = 8'h0e;
	localparam logic [7:0] ADDR_POLARITY = 8'h0f;
	localparam logic [7:0] ADDR_FLAGS    = 8'h10;

	// device_control field positions
	localparam int CTL_SW_RESET_N   = 7;
	localparam int CTL_SW_SYNC_N    = 6;
	localparam int CTL_AUTO_SYNC    = 4;
	localparam int CTL_SYNC_MUTE    = 3;
	localparam int CTL_SYSCLK_SRC   = 2;
	localparam int CTL_PLL_ORDER    = 1;
	localparam int CTL_AUTO_START   = 0;

	// interrupt source positions (same for live, mask, polarity, flags)
	localparam int SRC_A_LOL        = 7;
	localparam int SRC_A_LOS        = 6;
	localparam int SRC_A_CAL        = 5;
	localparam int SRC_B_LOL        = 4;
	localparam int SRC_B_LOS        = 3;
	localparam int SRC_B_CAL        = 2;
	localparam int SRC_A_SWITCHBACK = 1;
	localparam int SRC_B_SWITCHBACK = 0;

	// reset values and write masks
	localparam logic [7:0] CONTROL_RESET  = 8'hd9;
	localparam logic [7:0] CONTROL_WMASK  = 8'hdf;
	localparam logic [7:0] REVISION_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET     = 8'h00;
	localparam logic [7:0] POLARITY_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET    = 8'h00;
	localparam logic [7:0] LIVE_RESET     = 8'h00;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;

	// timing
	localparam int CLK_PERIOD_PS       = 5000;
	localparam int AUTO_SYNC_HOLD_NS   = 100;
	localparam logic [7:0] AUTO_SYNC_CYCLES =
		8'((AUTO_SYNC_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	typedef enum logic [2:0] {
		ST_HALT      = 3'b000,
		ST_WAIT_A    = 3'b001,
		ST_WAIT_LOCK = 3'b010,
		ST_AUTO_SYNC = 3'b011,
		ST_RUN       = 3'b100
	} dci_seq_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} dci_reg_req_t;

	typedef struct packed {
		logic pll_a_cal_start;
		logic pll_b_cal_start;
		logic core_reset;
		logic outputs_enable;
		logic outputs_mute;
		logic sync_active;
		logic sysclk_after_lock;
		logic revision_load_req;
	} dci_device_control_t;

	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] flags;
	} dci_flag_state_t;
endpackage
`default_nettype wire

// ==== rtl/dci_edge_flags.sv ====
`default_nettype none
module dci_edge_flags (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] src_i,
	input  wire logic [7:0] polarity_i,
	input  wire logic       clear_we_i,
	input  wire logic [7:0] clear_data_i,
	output logic      [7:0] flags_o
);
	dci_pkg::dci_flag_state_t s_q;
	dci_pkg::dci_flag_state_t s_d;
	logic [7:0]               edge_hit;
	logic [7:0]               keep;

	always_comb begin
		s_d      = s_q;
		edge_hit = (polarity_i & src_i & ~s_q.prev) | (~polarity_i & ~src_i & s_q.prev); // RL14
		keep     = clear_we_i ? clear_data_i : 8'hff; // RL14
		s_d.prev  = src_i;
		s_d.flags = (s_q.flags & keep) | edge_hit; // RL14
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_q.prev  <= dci_pkg::LIVE_RESET;
			s_q.flags <= dci_pkg::FLAGS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_o = s_q.flags;
endmodule
`default_nettype wire

// ==== rtl/dci_ctrl_regs.sv ====
`default_nettype none
// Function
// [RL1] revision byte reloaded from nonvolatile memory after each reset and commit
// [RL2] software reset bit low holds device in reset, registers untouched
// [RL3] software sync bit low acts like the sync input pin; resets high
// [RL4] auto sync bit set: one synchronisation after lock at startup; resets high
// [RL5] sync mute bit set mutes all outputs while synchronising
// [RL6] control bit 2 selects system clock source once lock is reached
// [RL7] order bit set: both plls calibrate together; second always recalibrates
// [RL8] auto start set: lock and enable after reset; clear: halt until set
// [RL9] power-on, reset pin and software reset all restart the startup sequence
// [RL10] live status shows the present level of all eight sources, unmasked
// [RL11] live bits: a lol, a los, a cal, b lol, b los, b cal, switchbacks
// [RL12] mask bit set keeps its source off the interrupt output; resets 0
// [RL13] live status and revision are read-only; live reads 0 after reset
// [RL14] flag set by programmed edge of its source, cleared by writing 0
// [RL15] reserved control bits ignore writes and read back 0
// [RL16] software reset and sync bits act as levels while low only
module dci_ctrl_regs (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  external_reset_pin_n_i,
	input  wire logic                  sync_input_pin_i,
	input  wire dci_pkg::dci_reg_req_t reg_req_i,
	input  wire logic                  pll_a_locked_i,
	input  wire logic                  pll_b_locked_i,
	input  wire logic                  pll_a_loss_of_lock_i,
	input  wire logic                  pll_a_loss_of_signal_i,
	input  wire logic                  pll_a_calibrating_i,
	input  wire logic                  pll_b_loss_of_lock_i,
	input  wire logic                  pll_b_loss_of_signal_i,
	input  wire logic                  pll_b_calibrating_i,
	input  wire logic                  pll_a_ref_switchback_i,
	input  wire logic                  pll_b_ref_switchback_i,
	input  wire logic                  nvm_commit_done_i,
	input  wire logic                  nvm_revision_valid_i,
	input  wire logic            [7:0] nvm_revision_i,
	output logic                 [7:0] reg_rdata_o,
	output logic                       reg_rvalid_o,
	output logic                       interrupt_o,
	output dci_pkg::dci_device_control_t      device_control_o
);
	typedef struct packed {
		logic [7:0]            device_control;
		logic [7:0]            image_revision;
		logic [7:0]            interrupt_live_status;
		logic [7:0]            interrupt_source_mask;
		logic [7:0]            flag_polarity;
		dci_pkg::dci_seq_t     seq;
		logic [7:0]            sync_cnt;
		logic [7:0]            rdata;
		logic                  rvalid;
		logic                  irq;
		dci_pkg::dci_device_control_t ctl;
	} dci_state_t;

	dci_state_t s_q;
	dci_state_t s_d;
	logic [7:0] sources;
	logic [7:0] flags;
	logic       dev_reset;
	logic       sync_req;
	logic       flag_clear_we;

	function automatic logic hit(input dci_pkg::dci_reg_req_t req, input logic [7:0] addr);
		hit = req.wr && (req.addr == addr);
	endfunction

	always_comb begin
		sources = '0;
		sources[dci_pkg::SRC_A_LOL]        = pll_a_loss_of_lock_i; // RL11
		sources[dci_pkg::SRC_A_LOS]        = pll_a_loss_of_signal_i; // RL11
		sources[dci_pkg::SRC_A_CAL]        = pll_a_calibrating_i; // RL11
		sources[dci_pkg::SRC_B_LOL]        = pll_b_loss_of_lock_i; // RL11
		sources[dci_pkg::SRC_B_LOS]        = pll_b_loss_of_signal_i; // RL11
		sources[dci_pkg::SRC_B_CAL]        = pll_b_calibrating_i; // RL11
		sources[dci_pkg::SRC_A_SWITCHBACK] = pll_a_ref_switchback_i; // RL11
		sources[dci_pkg::SRC_B_SWITCHBACK] = pll_b_ref_switchback_i; // RL11
	end

	assign flag_clear_we = hit(reg_req_i, dci_pkg::ADDR_FLAGS);

	dci_edge_flags u_flags (
		.ref_clk_i    (ref_clk_i),
		.rst_n_i      (rst_n_i),
		.src_i        (s_q.interrupt_live_status),
		.polarity_i   (s_q.flag_polarity),
		.clear_we_i   (flag_clear_we),
		.clear_data_i (reg_req_i.wdata),
		.flags_o      (flags)
	);

	always_comb begin
		s_d = s_q;

		// device reset from pin or software bit; registers are kept
		dev_reset = !external_reset_pin_n_i
			|| !s_q.device_control[dci_pkg::CTL_SW_RESET_N]; // RL2 RL9 RL16
		sync_req  = !s_q.device_control[dci_pkg::CTL_SW_SYNC_N]
			|| sync_input_pin_i; // RL3 RL16

		// register writes
		if (hit(reg_req_i, dci_pkg::ADDR_CONTROL)) begin
			s_d.device_control = reg_req_i.wdata & dci_pkg::CONTROL_WMASK; // RL15
		end else if (hit(reg_req_i, dci_pkg::ADDR_MASK)) begin
			s_d.interrupt_source_mask = reg_req_i.wdata; // RL12
		end else if (hit(reg_req_i, dci_pkg::ADDR_POLARITY)) begin
			s_d.flag_polarity = reg_req_i.wdata;
		end

		// live view of sources, never gated
		s_d.interrupt_live_status = sources; // RL10

		// revision reload after reset release or commit
		s_d.ctl.revision_load_req = (s_q.ctl.core_reset && !dev_reset)
			|| nvm_commit_done_i; // RL1
		if (nvm_revision_valid_i) begin
			s_d.image_revision = nvm_revision_i; // RL1
		end

		// interrupt output
		s_d.irq = |(s_q.interrupt_live_status & ~s_q.interrupt_source_mask); // RL12

		// register reads, one cycle latency
		s_d.rvalid = reg_req_i.rd;
		if (!reg_req_i.rd) begin
			s_d.rdata = s_q.rdata;
		end else if (reg_req_i.addr == dci_pkg::ADDR_REVISION) begin
			s_d.rdata = s_q.image_revision; // RL13
		end else if (reg_req_i.addr == dci_pkg::ADDR_CONTROL) begin
			s_d.rdata = s_q.device_control & dci_pkg::CONTROL_WMASK; // RL15
		end else if (reg_req_i.addr == dci_pkg::ADDR_LIVE) begin
			s_d.rdata = s_q.interrupt_live_status; // RL13
		end else if (reg_req_i.addr == dci_pkg::ADDR_MASK) begin
			s_d.rdata = s_q.interrupt_source_mask;
		end else if (reg_req_i.addr == dci_pkg::ADDR_POLARITY) begin
			s_d.rdata = s_q.flag_polarity;
		end else if (reg_req_i.addr == dci_pkg::ADDR_FLAGS) begin
			s_d.rdata = flags; // RL14
		end else begin
			s_d.rdata = dci_pkg::READ_UNMAPPED;
		end

		// startup sequencer
		s_d.ctl.pll_a_cal_start = 1'b0;
		s_d.ctl.pll_b_cal_start = 1'b0;
		s_d.ctl.core_reset      = dev_reset; // RL2 RL9
		if (dev_reset) begin
			s_d.seq      = dci_pkg::ST_HALT; // RL9
			s_d.sync_cnt = '0;
		end else begin
			case (s_q.seq)
				dci_pkg::ST_HALT: begin
					if (s_q.device_control[dci_pkg::CTL_AUTO_START]) begin // RL8
						s_d.ctl.pll_a_cal_start = 1'b1;
						if (s_q.device_control[dci_pkg::CTL_PLL_ORDER]) begin
							s_d.ctl.pll_b_cal_start = 1'b1; // RL7
							s_d.seq = dci_pkg::ST_WAIT_LOCK;
						end else begin
							s_d.seq = dci_pkg::ST_WAIT_A;
						end
					end
				end
				dci_pkg::ST_WAIT_A: begin
					// a lock seen right after the start pulse is stale
					if (pll_a_locked_i && !s_q.ctl.pll_a_cal_start) begin
						s_d.ctl.pll_b_cal_start = 1'b1;
						s_d.seq = dci_pkg::ST_WAIT_LOCK;
					end
				end
				dci_pkg::ST_WAIT_LOCK: begin
					if (pll_a_locked_i && pll_b_locked_i && !s_q.ctl.pll_a_cal_start
						&& !s_q.ctl.pll_b_cal_start) begin
						if (s_q.device_control[dci_pkg::CTL_AUTO_SYNC]) begin // RL4
							s_d.seq      = dci_pkg::ST_AUTO_SYNC;
							s_d.sync_cnt = dci_pkg::AUTO_SYNC_CYCLES;
						end else begin
							s_d.seq = dci_pkg::ST_RUN;
						end
					end
				end
				dci_pkg::ST_AUTO_SYNC: begin
					s_d.sync_cnt = s_q.sync_cnt - 8'h01; // RL4
					if (s_q.sync_cnt == 8'h01) begin
						s_d.seq = dci_pkg::ST_RUN;
					end
				end
				dci_pkg::ST_RUN: begin
					s_d.seq = dci_pkg::ST_RUN;
				end
				default: begin
					s_d.seq = dci_pkg::ST_HALT;
				end
			endcase
		end

		// output drive after the sequencer decision
		s_d.ctl.sync_active = !dev_reset && ((s_d.seq == dci_pkg::ST_AUTO_SYNC)
			|| (s_d.seq == dci_pkg::ST_RUN && sync_req)); // RL3 RL4
		s_d.ctl.outputs_mute = s_d.ctl.sync_active
			&& s_q.device_control[dci_pkg::CTL_SYNC_MUTE]; // RL5
		s_d.ctl.outputs_enable = !dev_reset && !s_d.ctl.outputs_mute
			&& ((s_d.seq == dci_pkg::ST_RUN) || (s_d.seq == dci_pkg::ST_AUTO_SYNC)); // RL5 RL8
		s_d.ctl.sysclk_after_lock = !dev_reset
			&& s_q.device_control[dci_pkg::CTL_SYSCLK_SRC]
			&& ((s_d.seq == dci_pkg::ST_RUN) || (s_d.seq == dci_pkg::ST_AUTO_SYNC)); // RL6
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_q.device_control        <= dci_pkg::CONTROL_RESET; // RL3 RL4
			s_q.image_revision        <= dci_pkg::REVISION_RESET;
			s_q.interrupt_live_status <= dci_pkg::LIVE_RESET; // RL13
			s_q.interrupt_source_mask <= dci_pkg::MASK_RESET; // RL12
			s_q.flag_polarity         <= dci_pkg::POLARITY_RESET;
			s_q.seq                   <= dci_pkg::ST_HALT;
			s_q.sync_cnt              <= '0;
			s_q.rdata                 <= '0;
			s_q.rvalid                <= 1'b0;
			s_q.irq                   <= 1'b0;
			s_q.ctl                   <= '0;
			s_q.ctl.core_reset        <= 1'b1; // RL1 RL9
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o  = s_q.rdata;
	assign reg_rvalid_o = s_q.rvalid;
	assign interrupt_o  = s_q.irq;
	assign device_control_o    = s_q.ctl;
endmodule
`default_nettype wire

// ==== testbench/dci_pll_model.sv ====
`default_nettype none
// one pll: calibrates for a fixed time after each start pulse, then holds lock
module dci_pll_model #(
	parameter int LOCK_CYCLES = 10
) (
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic cal_start_i,
	output wire logic locked_o,
	output wire logic calibrating_o
);
	int cnt_q;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i)
			cnt_q <= 0;
		else if (cal_start_i)
			cnt_q <= LOCK_CYCLES;
		else if (cnt_q > 1)
			cnt_q <= cnt_q - 1;
	end
	assign calibrating_o = cnt_q > 1;
	assign locked_o = cnt_q == 1;
endmodule
`default_nettype wire

// ==== testbench/dci_ctrl_regs_sva.sv ====
`default_nettype none
module dci_ctrl_regs_sva (
	input wire logic                  ref_clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  external_reset_pin_n_i,
	input wire dci_pkg::dci_reg_req_t reg_req_i,
	input wire logic                  pll_a_loss_of_lock_i,
	input wire logic                  pll_a_loss_of_signal_i,
	input wire logic                  pll_a_calibrating_i,
	input wire logic                  pll_b_loss_of_lock_i,
	input wire logic                  pll_b_loss_of_signal_i,
	input wire logic                  pll_b_calibrating_i,
	input wire logic                  pll_a_ref_switchback_i,
	input wire logic                  pll_b_ref_switchback_i,
	input wire logic [7:0]            reg_rdata_o,
	input wire logic                  reg_rvalid_o,
	input wire logic                  interrupt_o,
	input wire dci_pkg::dci_device_control_t device_control_o
);
	logic [7:0] live;
	logic [7:0] ctl_h;
	logic [7:0] mask_h;
	assign live = {pll_a_loss_of_lock_i, pll_a_loss_of_signal_i, pll_a_calibrating_i,
		pll_b_loss_of_lock_i, pll_b_loss_of_signal_i, pll_b_calibrating_i,
		pll_a_ref_switchback_i, pll_b_ref_switchback_i};
	// shadow of the control and mask registers
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ctl_h <= 8'hd9;
			mask_h <= 8'h00;
		end else if (reg_req_i.wr && reg_req_i.addr == 8'h0c) begin
			ctl_h <= reg_req_i.wdata & 8'hdf;
		end else if (reg_req_i.wr && reg_req_i.addr == 8'h0e) begin
			mask_h <= reg_req_i.wdata;
		end
	end
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_rd(logic [7:0] a);
		reg_req_i.rd && reg_req_i.addr == a;
	endsequence
	ctl_read_a: assert property (s_rd(8'h0c) |=>
		reg_rvalid_o && reg_rdata_o == $past(ctl_h)) else $error("control readback");
	mask_read_a: assert property (s_rd(8'h0e) |=>
		reg_rdata_o == $past(mask_h)) else $error("mask readback");
	live_read_a: assert property (s_rd(8'h0d) ##0 $stable(live) |=>
		reg_rdata_o == $past(live)) else $error("live status readback");
	irq_mask_a: assert property ($stable(live) && $stable(mask_h) |=>
		interrupt_o == |($past(live) & ~$past(mask_h))) else $error("interrupt level");
	pin_reset_a: assert property (!external_reset_pin_n_i |=>
		device_control_o.core_reset && !device_control_o.outputs_enable) else $error("pin reset");
	sw_reset_a: assert property (reg_req_i.wr && reg_req_i.addr == 8'h0c
		&& !reg_req_i.wdata[7] |-> ##2 device_control_o.core_reset) else $error("software reset");
	sync_mute_a: assert property (device_control_o.outputs_mute |->
		device_control_o.sync_active && !device_control_o.outputs_enable) else $error("mute");
	pll_order_a: assert property (device_control_o.pll_a_cal_start && $past(ctl_h[1]) |->
		device_control_o.pll_b_cal_start) else $error("parallel calibration");
	start_go_a: assert property ($fell(device_control_o.core_reset) && ctl_h[0] |->
		##[0:2] device_control_o.pll_a_cal_start) else $error("auto start");
	start_halt_a: assert property ($fell(device_control_o.core_reset) && !ctl_h[0] |=>
		!device_control_o.pll_a_cal_start [*3]) else $error("halt");
endmodule
bind dci_ctrl_regs dci_ctrl_regs_sva dci_ctrl_regs_sva_i (.ref_clk_i, .rst_n_i,
	.external_reset_pin_n_i, .reg_req_i, .pll_a_loss_of_lock_i, .pll_a_loss_of_signal_i,
	.pll_a_calibrating_i, .pll_b_loss_of_lock_i, .pll_b_loss_of_signal_i,
	.pll_b_calibrating_i, .pll_a_ref_switchback_i, .pll_b_ref_switchback_i,
	.reg_rdata_o, .reg_rvalid_o, .interrupt_o, .device_control_o);
`default_nettype wire

// ==== testbench/dci_ctrl_regs_tb.sv ====
`default_nettype none
module dci_ctrl_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic external_reset_pin_n_i = 1'b1;
	logic sync_input_pin_i = 1'b0;
	logic nvm_commit_done_i = 1'b0;
	logic nvm_revision_valid_i = 1'b0;
	logic [7:0] nvm_revision_i = 8'h00;
	logic [7:0] src = 8'h00;
	dci_pkg::dci_reg_req_t reg_req_i = '0;
	logic pll_a_locked_i, pll_b_locked_i, pll_a_calibrating_i, pll_b_calibrating_i;
	logic [7:0] reg_rdata_o;
	logic reg_rvalid_o, interrupt_o;
	dci_pkg::dci_device_control_t device_control_o;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] ncal, ncb, nsync, nrev;
	always #2.5 ref_clk_i = ~ref_clk_i;
	dci_ctrl_regs dci_ctrl_regs_i (.ref_clk_i, .rst_n_i, .external_reset_pin_n_i,
		.sync_input_pin_i, .reg_req_i, .pll_a_locked_i, .pll_b_locked_i,
		.pll_a_loss_of_lock_i(src[7]), .pll_a_loss_of_signal_i(src[6]), .pll_a_calibrating_i,
		.pll_b_loss_of_lock_i(src[4]), .pll_b_loss_of_signal_i(src[3]), .pll_b_calibrating_i,
		.pll_a_ref_switchback_i(src[1]), .pll_b_ref_switchback_i(src[0]), .nvm_commit_done_i,
		.nvm_revision_valid_i, .nvm_revision_i, .reg_rdata_o, .reg_rvalid_o, .interrupt_o,
		.device_control_o);
	dci_pll_model #(.LOCK_CYCLES(10)) dci_pll_model_i (.ref_clk_i, .rst_n_i,
		.cal_start_i(device_control_o.pll_a_cal_start), .locked_o(pll_a_locked_i),
		.calibrating_o(pll_a_calibrating_i));
	dci_pll_model #(.LOCK_CYCLES(3)) dci_pll_model_b_i (.ref_clk_i, .rst_n_i,
		.cal_start_i(device_control_o.pll_b_cal_start), .locked_o(pll_b_locked_i),
		.calibrating_o(pll_b_calibrating_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge ref_clk_i);
		reg_req_i = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		reg_req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge ref_clk_i);
		chk(8'(reg_rvalid_o), 8'h01);
		chk(reg_rdata_o, exp);
		reg_req_i = '0;
	endtask
	// counts start pulses and sync cycles; sync is counted only while muted
	task automatic run(input int n);
		ncal = 8'h00;
		ncb = 8'h00;
		nsync = 8'h00;
		nrev = 8'h00;
		repeat (n) begin
			@(posedge ref_clk_i);
			#1;
			ncal += 8'(device_control_o.pll_a_cal_start);
			ncb += 8'(device_control_o.pll_b_cal_start);
			nsync += 8'(device_control_o.sync_active && device_control_o.outputs_mute);
			nrev += 8'(device_control_o.revision_load_req);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		run(200);
		chk(nsync, dci_pkg::AUTO_SYNC_CYCLES);
		chk(nrev, 8'h01);
		chk(ncb, 8'h01);
		chk(8'(device_control_o.outputs_enable), 8'h01);
		rd(8'h0b, 8'h00);
		rd(8'h0c, 8'hd9);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h00);
		rd(8'h20, 8'h00);
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'hdf);
		chk(8'(device_control_o.sysclk_after_lock), 8'h01);
		@(negedge ref_clk_i);
		nvm_commit_done_i = 1'b1;
		@(negedge ref_clk_i);
		chk(8'(device_control_o.revision_load_req), 8'h01);
		nvm_commit_done_i = 1'b0;
		nvm_revision_i = 8'h5a;
		nvm_revision_valid_i = 1'b1;
		@(negedge ref_clk_i);
		nvm_revision_valid_i = 1'b0;
		wr(8'h0b, 8'hff);
		rd(8'h0b, 8'h5a);
		for (int i = 0; i < 8; i++) begin
			if (i == 2 || i == 5)
				continue;
			@(negedge ref_clk_i);
			src = 8'h01 << i;
			rd(8'h0d, src);
			chk(8'(interrupt_o), 8'h01);
			wr(8'h0e, src);
			rd(8'h0e, src);
			chk(8'(interrupt_o), 8'h00);
			wr(8'h0e, 8'h00);
		end
		@(negedge ref_clk_i);
		src = 8'h00;
		run(3);
		rd(8'h10, 8'hff);
		wr(8'h10, 8'h0f);
		rd(8'h10, 8'h0f);
		wr(8'h0f, 8'hff);
		src = 8'h80;
		run(3);
		rd(8'h10, 8'h8f);
		wr(8'h0c, 8'h59);
		run(3);
		chk(8'(device_control_o.core_reset), 8'h01);
		rd(8'h10, 8'h8f);
		wr(8'h0c, 8'hd8);
		run(30);
		chk(ncal, 8'h00);
		wr(8'h0c, 8'hdb);
		run(100);
		chk(ncal, 8'h01);
		chk(ncb, 8'h01);
		chk(nsync, dci_pkg::AUTO_SYNC_CYCLES);
		wr(8'h0c, 8'h9b);
		run(4);
		chk(8'(device_control_o.outputs_mute), 8'h01);
		wr(8'h0c, 8'hd3);
		run(4);
		chk(8'(device_control_o.sync_active), 8'h00);
		@(negedge ref_clk_i);
		sync_input_pin_i = 1'b1;
		run(4);
		chk(8'(device_control_o.sync_active), 8'h01);
		chk(8'(device_control_o.outputs_enable), 8'h01);
		@(negedge ref_clk_i);
		sync_input_pin_i = 1'b0;
		external_reset_pin_n_i = 1'b0;
		run(3);
		chk(8'(device_control_o.core_reset), 8'h01);
		@(negedge ref_clk_i);
		external_reset_pin_n_i = 1'b1;
		run(100);
		chk(ncal, 8'h01);
		chk(nrev, 8'h01);
		stop_test;
	end
endmodule
`default_nettype wire
